/* File: design/ssp_spi.sv */
// spi mode of the synchronous serial port, with apb register access
`timescale 1ns/10ps
`include "ssp_spi_regs.svh"

// Function
// - drive on one edge, sample on opposite
// - buffer write starts master transfer immediately
// - master with clock input keeps receiving
// - slave shifts on external clock, sets flag
// - polarity from control bit four
// - most significant bit first
// - master rates div4, div16, div64, timer/2
// - slave works in sleep, wakes device
// - select gating only mode 04h, pin input
// - select low enables shifting, drives output
// - select high floats data output
// - select return resumes at same bit
// - data output as input stops transmission
// - mode field codes master and slave modes
// - busy write discarded, sets collision flag
// - full byte loads buffer, flags; read clears
// - slave overflow keeps old byte, flags
module ssp_spi
    import ssp_spi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_tick, // second timer period match pulse
    input wire logic sclk_in, // serial clock pin level
    output logic sclk_out,
    output logic sclk_oe_n, // low while the clock pin is driven
    input wire logic data_in, // serial data input pin
    output logic data_out,
    output logic data_out_oe_n, // low while data output is driven
    input wire logic select_n, // slave select pin, active low
    output logic port_irq, // level interrupt
    output logic wake // sleep wake request
);
    // registers
    logic [7:0] peripheral_int_flags;
    logic [7:0] peripheral_int_enables;
    logic [7:0] serial_port_control;
    logic [7:0] transfer_buffer;
    logic buffer_full_flag;
    logic [2:0] port_direction; // clock, data out, select: 1 = input
    logic sleeping; // device sleep state
    // shifter state
    logic [7:0] shift_register, tx_byte; // receive shifter, byte to send
    logic [2:0] bit_count, out_count; // bits sampled, bits driven
    logic busy;
    logic out_bit;
    master_phase_type phase;
    logic [5:0] div_count;
    logic [3:0] samp_pipe; // master sample strobe, delayed
    // synchronisers, three stages each
    logic [2:0] sclk_sync, data_sync, sel_sync;
    logic sclk_level, sel_level, sclk_prev;

    // decoded controls
    logic enabled, polarity, master, slave, gated, selected;
    logic [3:0] mode;
    assign mode = serial_port_control[`CTL_MODE_HI:`CTL_MODE_LO];
    assign enabled = serial_port_control[`CTL_ENABLE_BIT];
    assign polarity = serial_port_control[`CTL_POLARITY_BIT];
    assign master = enabled && (mode <= `MODE_MASTER_TIMER);
    assign slave = enabled && (mode == `MODE_SLAVE_SELECT
        || mode == `MODE_SLAVE_FREE);
    assign gated = (mode == `MODE_SLAVE_SELECT)
        && port_direction[`DIR_SELECT_BIT];
    assign selected = !gated || !sel_level;

    // byte address from register index
    function automatic logic hit(input logic [31:0] a, input logic [7:0] i);
        hit = (a[31:2] == {22'h000000, i}) && (a[1:0] == 2'h0);
    endfunction : hit

    // bus phases
    logic wr_access, rd_access, mapped;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign mapped = hit(paddr, `IDX_PERIPHERAL_INT_FLAGS)
        || hit(paddr, `IDX_SERIAL_TRANSFER_BUFFER)
        || hit(paddr, `IDX_SERIAL_PORT_CONTROL)
        || hit(paddr, `IDX_PERIPHERAL_INT_ENABLES)
        || hit(paddr, `IDX_SERIAL_PORT_STATUS)
        || hit(paddr, `IDX_PORT_DIRECTION)
        || hit(paddr, `IDX_PORT_SLEEP);
    logic buf_write, buf_read;
    assign buf_write = wr_access && hit(paddr, `IDX_SERIAL_TRANSFER_BUFFER);
    assign buf_read = rd_access && hit(paddr, `IDX_SERIAL_TRANSFER_BUFFER);

    // pin synchronisers: each stage feeds the next
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_sync <= 3'h0;
            data_sync <= 3'h0;
            sel_sync <= 3'h7;
            sclk_level <= 1'b0;
            sel_level <= 1'b1;
            sclk_prev <= 1'b0;
        end
        else
        begin
            sclk_prev <= sclk_level;
            sclk_sync <= {sclk_sync[1:0], sclk_in};
            data_sync <= {data_sync[1:0], data_in};
            sel_sync <= {sel_sync[1:0], select_n};
            // a change counts when stages two and three agree
            if (sclk_sync[1] == sclk_sync[2])
                sclk_level <= sclk_sync[2];
            if (sel_sync[1] == sel_sync[2])
                sel_level <= sel_sync[2];
        end
    end

    // slave clock edges relative to polarity
    logic ext_lead, ext_trail;
    // leading edge leaves idle level: data changes; trailing: sample
    assign ext_lead = (sclk_level != sclk_prev) && (sclk_prev == polarity);
    assign ext_trail = (sclk_level != sclk_prev) && (sclk_level == polarity);

    // master bit clock generator
    logic [5:0] half_len;
    logic half_tick;
    always_comb
    begin
        unique case (mode[1:0])
            2'h0: half_len = `HALF_DIV4;
            2'h1: half_len = `HALF_DIV16;
            2'h2: half_len = `HALF_DIV64;
            2'h3: half_len = 6'h01;
        endcase
    end
    // timer rate: each half period ends on a timer tick, so bit = timer/2
    assign half_tick = (mode[1:0] == 2'h3) ? timer_tick
        : (div_count == half_len - 6'h01);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_count <= 6'h00;
            samp_pipe <= 4'h0;
        end
        else
        begin
            // data in lags the wire by the pin flop and three sync flops,
            // so the master samples four cycles after its trailing edge
            samp_pipe <= {samp_pipe[2:0],
                master && phase == high_type_s && half_tick};
            div_count <= (phase == idle_type_s || half_tick) ? 6'h00
                : div_count + 6'h01;
        end
    end

    // events of the shifter
    logic shift_edge, sample_edge, byte_done;
    assign sample_edge = master ? samp_pipe[3]
        : (slave && selected && ext_trail);
    assign shift_edge = master ? (phase == low_type_s && half_tick)
        : (slave && selected && ext_lead);
    assign byte_done = sample_edge && busy && bit_count == `LAST_BIT;

    // master phase: low = idle level, ends in the leading edge; high after
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase <= idle_type_s;
        else if (!master)
            phase <= idle_type_s;
        else
            unique case (phase)
                idle_type_s:
                    if (buf_write && !busy)
                        phase <= low_type_s;
                low_type_s:
                    if (half_tick)
                        phase <= high_type_s;
                high_type_s:
                    if (half_tick)
                        phase <= (out_count == 3'h0) ? idle_type_s
                            : low_type_s;
            endcase
    end

    // shift registers and bit counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_register <= `RESET_BYTE;
            tx_byte <= `RESET_BYTE;
            bit_count <= 3'h0;
            out_count <= 3'h0;
            busy <= 1'b0;
            out_bit <= 1'b0;
        end
        else if (buf_write && !busy)
        begin
            // a write while disabled preloads the byte for a later slave
            tx_byte <= pwdata[7:0];
            out_bit <= pwdata[7];
            bit_count <= 3'h0;
            out_count <= 3'h0;
            busy <= 1'b1;
        end
        else if (!enabled)
        begin
            // clearing enable resets the port, dropping a partial byte
            bit_count <= 3'h0;
            out_count <= 3'h0;
            busy <= 1'b0;
        end
        else
        begin
            // counts survive select going high, so shifting resumes
            if (sample_edge)
            begin
                shift_register <= {shift_register[6:0], data_sync[2]};
                busy <= 1'b1;
                bit_count <= bit_count + 3'h1;
                if (bit_count == `LAST_BIT)
                    busy <= slave; // slave stays armed for next byte
            end
            if (shift_edge)
            begin
                out_bit <= tx_byte[`LAST_BIT - out_count];
                out_count <= out_count + 3'h1;
            end
        end
    end

    // serial clock pin: master drives only if its direction is output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_out <= 1'b0;
            sclk_oe_n <= 1'b1;
        end
        else
        begin
            // line monitor: clock pin as input still clocks
            sclk_out <= (phase == high_type_s) ? !polarity : polarity;
            sclk_oe_n <= !(master && !port_direction[`DIR_CLOCK_BIT]);
        end
    end

    // data output pin driver
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_out <= 1'b0;
            data_out_oe_n <= 1'b1;
        end
        else
        begin
            data_out <= out_bit;
            // direction input suppresses it select high floats
            data_out_oe_n <= !((master || (slave && selected))
                && !port_direction[`DIR_DATA_OUT_BIT]);
        end
    end

    // receive buffer, full flag, collision and overflow
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            transfer_buffer <= `RESET_BYTE;
            buffer_full_flag <= 1'b0;
            serial_port_control <= 8'h00;
        end
        else
        begin
            if (wr_access && hit(paddr, `IDX_SERIAL_PORT_CONTROL))
                serial_port_control <= pwdata[7:0];
            if (buf_read)
                buffer_full_flag <= 1'b0;
            if (byte_done)
            begin
                if (slave && buffer_full_flag && !buf_read)
                    serial_port_control[`CTL_OVERFLOW_BIT] <= 1'b1;
                else
                begin
                    transfer_buffer <= {shift_register[6:0], data_sync[2]};
                    buffer_full_flag <= 1'b1;
                end
            end
            if (buf_write && busy)
                serial_port_control[`CTL_COLLISION_BIT] <= 1'b1;
        end
    end

    // flag, enable, direction and sleep registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            peripheral_int_flags <= 8'h00;
            peripheral_int_enables <= 8'h00;
            port_direction <= 3'h7;
            sleeping <= 1'b0;
        end
        else
        begin
            if (wr_access && hit(paddr, `IDX_PERIPHERAL_INT_ENABLES))
                peripheral_int_enables <= pwdata[7:0];
            if (wr_access && hit(paddr, `IDX_PORT_DIRECTION))
                port_direction <= pwdata[2:0];
            if (wr_access && hit(paddr, `IDX_PORT_SLEEP))
                sleeping <= pwdata[0];
            // flag register read clears flags; a new byte wins the same cycle
            if (rd_access && hit(paddr, `IDX_PERIPHERAL_INT_FLAGS))
                peripheral_int_flags <= 8'h00;
            if (byte_done)
                peripheral_int_flags[`FLAG_PORT_BIT] <= 1'b1;
            if (byte_done && slave)
                sleeping <= 1'b0;
        end
    end

    // interrupt and wake outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_irq <= 1'b0;
            wake <= 1'b0;
        end
        else
        begin
            port_irq <= |(peripheral_int_flags & peripheral_int_enables);
            wake <= sleeping && byte_done && slave;
        end
    end

    // apb read data and response, zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite)
            begin
                if (hit(paddr, `IDX_PERIPHERAL_INT_FLAGS))
                    prdata[7:0] <= peripheral_int_flags;
                if (hit(paddr, `IDX_SERIAL_TRANSFER_BUFFER))
                    prdata[7:0] <= transfer_buffer;
                if (hit(paddr, `IDX_SERIAL_PORT_CONTROL))
                    prdata[7:0] <= serial_port_control;
                if (hit(paddr, `IDX_PERIPHERAL_INT_ENABLES))
                    prdata[7:0] <= peripheral_int_enables;
                if (hit(paddr, `IDX_SERIAL_PORT_STATUS))
                    prdata[`STAT_FULL_BIT] <= buffer_full_flag;
                if (hit(paddr, `IDX_PORT_DIRECTION))
                    prdata[2:0] <= port_direction;
                if (hit(paddr, `IDX_PORT_SLEEP))
                    prdata[0] <= sleeping;
            end
        end
    end
endmodule : ssp_spi

/* File: design/ssp_spi_regs.svh */
// register offsets, field positions and timing counts of the serial port
`ifndef SSP_SPI_REGS_SVH
`define SSP_SPI_REGS_SVH
// printed offsets are not all multiples of four: they are word indices
`define IDX_PERIPHERAL_INT_FLAGS 8'h0c
`define IDX_SERIAL_TRANSFER_BUFFER 8'h13
`define IDX_SERIAL_PORT_CONTROL 8'h14
`define IDX_PERIPHERAL_INT_ENABLES 8'h8c
`define IDX_SERIAL_PORT_STATUS 8'h94
`define IDX_PORT_DIRECTION 8'h95
`define IDX_PORT_SLEEP 8'h96
// control register fields
`define CTL_COLLISION_BIT 7
`define CTL_OVERFLOW_BIT 6
`define CTL_ENABLE_BIT 5
`define CTL_POLARITY_BIT 4
`define CTL_MODE_HI 3
`define CTL_MODE_LO 0
// flag register bit for the port
`define FLAG_PORT_BIT 3
// status register buffer full bit
`define STAT_FULL_BIT 0
// direction register bits (1 = input)
`define DIR_CLOCK_BIT 0
`define DIR_DATA_OUT_BIT 1
`define DIR_SELECT_BIT 2
// mode codes
`define MODE_MASTER_DIV4 4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TIMER 4'h3
`define MODE_SLAVE_SELECT 4'h4
`define MODE_SLAVE_FREE 4'h5
// half bit periods in system clocks for each divided rate
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define RESET_BYTE 8'h00
`define LAST_BIT 3'h7
`endif

/* File: design/ssp_spi_pkg.sv */
// types shared by the serial port design
package ssp_spi_pkg;
    typedef enum logic [1:0] {idle_type_s, low_type_s, high_type_s}
        master_phase_type;
endpackage : ssp_spi_pkg

/* File: bench/ssp_spi_chk.sv */
// port level checker of the serial port block
`timescale 1ns/10ps
module ssp_spi_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sclk_out,
    input wire logic sclk_oe_n,
    input wire logic data_out_oe_n,
    input wire logic port_irq,
    input wire logic wake
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // two phases of one bus transfer
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // the answer is due at the first access edge, no waits
    a_ready_timely: assert property (setup_s ##1 access_s |-> pready)
        else $error("pready missing in first access cycle");
    a_ready_access: assert property (pready |-> access_s)
        else $error("pready outside an access phase");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // registers are at most eight bits wide, upper bits read zero
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits set");
    // pins released and no request right after reset
    a_reset_idle: assert property ($rose(presetn) |->
        sclk_oe_n && data_out_oe_n && !port_irq && !pready)
        else $error("outputs not idle after reset");
    // fastest rate still holds each clock level two cycles
    a_sclk_half: assert property ($changed(sclk_out) |=> $stable(sclk_out))
        else $error("serial clock level shorter than two cycles");
    a_wake_pulse: assert property (wake |=> !wake)
        else $error("wake longer than one cycle");
endmodule : ssp_spi_chk

/* File: bench/spi_partner.sv */
// far side spi shifter, answers a master or makes the clock itself
`timescale 1ns/10ps
module spi_partner (
    input wire logic pclk,
    input wire logic pol, // idle level, same polarity as the device
    input wire logic sck, // clock as seen on the wire
    input wire logic din, // line from the device data output
    output logic dout, // line into the device data input
    output logic sck_drv // clock made when acting as master
);
    logic [7:0] tx = 8'h00; // byte to send
    logic [7:0] rx = 8'h00; // byte received
    logic [3:0] cnt = 4'h8; // bits done, 8 means idle
    logic act = 1'b0; // clock away from idle
    initial dout = 1'b0;
    assign sck_drv = pol ^ act;
    // leading edge drives, trailing edge samples, msb first
    always @(sck)
    begin
        if (cnt >= 4'h8)
            dout = ~dout; // hold time over, no stale bit shown
        else if (sck !== pol)
            dout = tx[3'h7 - cnt[2:0]];
        else
        begin
            rx = {rx[6:0], din};
            cnt = cnt + 4'h1;
        end
    end
    task load(input logic [7:0] b);
        tx = b;
        cnt = 4'h0;
    endtask : load
    // slow clock, eight pclk per level, then a settling gap
    task clocks(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge pclk);
            act <= 1'b1;
            repeat (8) @(posedge pclk);
            act <= 1'b0;
        end
        repeat (8) @(posedge pclk);
    endtask : clocks
endmodule : spi_partner

/* File: bench/sync_serial_port_spi_mode_tb.sv */
// self-checking bench of the serial port block with an spi partner
`timescale 1ns/10ps
`include "ssp_spi_regs.svh"
module sync_serial_port_spi_mode_tb;
    logic pclk = 1'b0, presetn, psel, penable;
    logic pwrite, timer_tick, select_n;
    logic [31:0] paddr, pwdata, prdata, rdv;
    logic pready, pslverr, sclk_out, sclk_oe_n, data_out, data_out_oe_n;
    logic port_irq, wake, errv, sck, sck_drv, miso, mosi;
    logic pol; // partner clock idle level
    logic [1:0] tcnt = 2'h0; // timer match divider
    int failures = 0, n_checks = 0, wakes = 0;
    always #10 pclk = ~pclk;
    // clock wire: the device wins while its enable is low
    assign sck = sclk_oe_n ? sck_drv : sclk_out;
    // data line has a pull-up while released
    assign mosi = data_out_oe_n ? 1'b1 : data_out;
    ssp_spi DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_tick(timer_tick), .sclk_in(sck),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .data_in(miso),
        .data_out(data_out), .data_out_oe_n(data_out_oe_n),
        .select_n(select_n), .port_irq(port_irq), .wake(wake));
    spi_partner far (.pclk(pclk), .pol(pol), .sck(sck), .din(mosi),
        .dout(miso), .sck_drv(sck_drv));
    // timer match every fourth cycle, wake pulses counted
    always @(posedge pclk)
    begin
        tcnt <= tcnt + 2'h1;
        timer_tick <= &tcnt;
        if (wake === 1'b1)
            wakes <= wakes + 1;
    end
    task stop_test;
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    task check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one bus transfer; request held until pready is seen
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            failures++;
            stop_test();
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input string what, input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check(what, {24'h0, e}, rdv);
    endtask : rd
    // poll buffer full with a bounded count
    task wait_full;
        int k;
        for (k = 0; k < 400; k++)
        begin
            apb(1'b0, `IDX_SERIAL_PORT_STATUS, 8'h00);
            if (rdv[0] === 1'b1)
                break;
        end
        if (k == 400)
        begin
            failures++;
            stop_test();
        end
    endtask : wait_full
    task reset_values;
        rd("flags", `IDX_PERIPHERAL_INT_FLAGS, 8'h00);
        rd("control", `IDX_SERIAL_PORT_CONTROL, 8'h00);
        rd("enables", `IDX_PERIPHERAL_INT_ENABLES, 8'h00);
        rd("status", `IDX_SERIAL_PORT_STATUS, 8'h00);
        rd("direction", `IDX_PORT_DIRECTION, 8'h07);
        apb(1'b0, 8'h40, 8'h00);
        check("unmapped error", 32'h1, {31'h0, errv});
        check("unmapped data", 32'h0, rdv);
    endtask : reset_values
    // every master rate, both polarities, masked and unmasked irq
    task master_rates;
        int i;
        logic [7:0] txb, rxb, ctl;
        apb(1'b1, `IDX_PORT_DIRECTION, 8'h04);
        for (i = 0; i < 4; i++)
        begin
            txb = 8'hc1 ^ 8'(i);
            rxb = 8'h3a ^ 8'(i);
            pol = i[0];
            ctl = {3'b001, i[0], 2'b00, i[1:0]};
            apb(1'b1, `IDX_PERIPHERAL_INT_ENABLES, {4'h0, i[0], 3'h0});
            apb(1'b1, `IDX_SERIAL_PORT_CONTROL, ctl);
            far.load(rxb);
            apb(1'b1, `IDX_SERIAL_TRANSFER_BUFFER, txb);
            if (i == 2)
            begin
                apb(1'b1, `IDX_SERIAL_TRANSFER_BUFFER, ~txb);
                rd("collision", `IDX_SERIAL_PORT_CONTROL, ctl | 8'h80);
            end
            wait_full;
            check("irq", {31'h0, i[0]}, {31'h0, port_irq});
            rd("flags", `IDX_PERIPHERAL_INT_FLAGS, 8'h08);
            rd("rx byte", `IDX_SERIAL_TRANSFER_BUFFER, rxb);
            rd("status", `IDX_SERIAL_PORT_STATUS, 8'h00);
            check("irq clear", 32'h0, {31'h0, port_irq});
            check("partner rx", {24'h0, txb}, {24'h0, far.rx});
            apb(1'b1, `IDX_SERIAL_PORT_CONTROL, 8'h00);
        end
    endtask : master_rates
    // slave without select, woken from sleep, then an overflow
    task slave_free;
        pol = 1'b0;
        apb(1'b1, `IDX_PORT_DIRECTION, 8'h05);
        apb(1'b1, `IDX_SERIAL_TRANSFER_BUFFER, 8'hb4);
        apb(1'b1, `IDX_PORT_SLEEP, 8'h01);
        apb(1'b1, `IDX_SERIAL_PORT_CONTROL, 8'h25);
        far.load(8'h6d);
        far.clocks(8);
        wait_full;
        check("wake pulses", 32'h1, wakes);
        check("partner rx", 32'hb4, {24'h0, far.rx});
        far.load(8'h39);
        far.clocks(8);
        rd("overflow", `IDX_SERIAL_PORT_CONTROL, 8'h65);
        rd("kept byte", `IDX_SERIAL_TRANSFER_BUFFER, 8'h6d);
        rd("flags", `IDX_PERIPHERAL_INT_FLAGS, 8'h08);
    endtask : slave_free
    // slave with select, byte split by a deselect
    task slave_select;
        pol = 1'b1;
        apb(1'b1, `IDX_SERIAL_PORT_CONTROL, 8'h00);
        apb(1'b1, `IDX_SERIAL_TRANSFER_BUFFER, 8'h4e);
        apb(1'b1, `IDX_SERIAL_PORT_CONTROL, 8'h34);
        far.load(8'hd2);
        select_n <= 1'b0;
        far.clocks(4);
        check("driven", 32'h0, {31'h0, data_out_oe_n});
        select_n <= 1'b1;
        far.clocks(0);
        check("released", 32'h1, {31'h0, data_out_oe_n});
        select_n <= 1'b0;
        far.clocks(4);
        wait_full;
        rd("resumed byte", `IDX_SERIAL_TRANSFER_BUFFER, 8'hd2);
        check("partner rx", 32'h4e, {24'h0, far.rx});
    endtask : slave_select
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        select_n = 1'b1;
        paddr = 32'h0;
        pwdata = 32'h0;
        pol = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_values;
        master_rates;
        slave_free;
        slave_select;
        stop_test;
    end
endmodule : sync_serial_port_spi_mode_tb
bind ssp_spi ssp_spi_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .data_out_oe_n(data_out_oe_n), .port_irq(port_irq), .wake(wake));
